// *** common/timer8_pkg.sv ***
package timer8_pkg;

  // ****************************************
  // Bus carriers.
  // ****************************************
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_s;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } wb_rsp_s;

  // ****************************************
  // Register indices, byte address is four times the index.
  // ****************************************
  localparam logic [5:0] IDX_FLAG    = 6'h15;
  localparam logic [5:0] IDX_CTRL    = 6'h24;
  localparam logic [5:0] IDX_COUNT   = 6'h26;
  localparam logic [5:0] IDX_COMPARE = 6'h27;
  localparam logic [5:0] IDX_MASK    = 6'h2E;
  localparam logic [5:0] IDX_PIN     = 6'h2F;

  // ****************************************
  // Field positions and reset values.
  // ****************************************
  localparam int CTRL_FOC    = 7;
  localparam int CTRL_WGM_LO = 6;
  localparam int CTRL_COM_HI = 5;
  localparam int CTRL_COM_LO = 4;
  localparam int CTRL_WGM_HI = 3;
  localparam int FLAG_OVF    = 0;
  localparam int FLAG_CMP    = 1;
  localparam int PIN_DIR     = 0;
  localparam int PIN_DATA    = 1;
  localparam logic [7:0] REG_RESET  = 8'h00;
  localparam logic [7:0] CNT_MAX    = 8'hFF;
  localparam logic [7:0] CNT_BOTTOM = 8'h00;

  // ****************************************
  // Prescaler taps for divide by 8, 64, 256 and 1024.
  // ****************************************
  localparam int PRE_W   = 10;
  localparam int PRE_8   = 3;
  localparam int PRE_64  = 6;
  localparam int PRE_256 = 8;

  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_PHASE  = 2'b01,
    MODE_CTC    = 2'b10,
    MODE_FAST   = 2'b11
  } mode_e;

  typedef enum logic [2:0] {
    CS_STOP  = 3'b000,
    CS_DIV1  = 3'b001,
    CS_DIV8  = 3'b010,
    CS_DIV64 = 3'b011,
    CS_DIV256 = 3'b100,
    CS_DIV1024 = 3'b101,
    CS_EXT_FALL = 3'b110,
    CS_EXT_RISE = 3'b111
  } cs_e;

  typedef struct packed {
    logic [PRE_W-1:0] cnt;
  } presc_s;

  typedef struct packed {
    logic [7:0]  count;
    logic [7:0]  ocr;
    logic [7:0]  ocr_buf;
    logic [7:0]  ctrl;
    logic [7:0]  mask;
    logic [1:0]  flags;
    logic [1:0]  pinc;
    logic        down;
    logic        block;
    logic        oc;
    logic        pin;
    logic        pin_oe_n;
    logic        irq;
    logic        ack;
    logic [31:0] rdat;
    logic [2:0]  sync;
  } tstate_s;

  localparam tstate_s TSTATE_RESET = '{
    count: REG_RESET, ocr: REG_RESET, ocr_buf: REG_RESET, ctrl: REG_RESET, mask: REG_RESET,
    flags: 2'h0, pinc: 2'h0, down: 1'b0, block: 1'b0, oc: 1'b0, pin: 1'b0, pin_oe_n: 1'b1,
    irq: 1'b0, ack: 1'b0, rdat: 32'h0000_0000, sync: 3'h0};

endpackage

// *** core/prescale_div.sv ***
`timescale 1ns/100ps
module prescale_div (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  output logic [3:0]      tick_o
);
  import timer8_pkg::*;

  presc_s s_q;
  presc_s s_d;

  // ****************************************
  // Free running divider, one enable pulse per tap period.
  // ****************************************
  always_comb begin
    s_d     = s_q;
    s_d.cnt = s_q.cnt + 1'b1;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick_o[0] = &s_q.cnt[PRE_8-1:0];
  assign tick_o[1] = &s_q.cnt[PRE_64-1:0];
  assign tick_o[2] = &s_q.cnt[PRE_256-1:0];
  assign tick_o[3] = &s_q.cnt;

endmodule

// *** core/timer8_core.sv ***
`timescale 1ns/100ps
// Behaviour
// RULE1 - Nonzero output mode drives pin from compare output, only when direction is output.
// RULE2 - Non-PWM modes: 00 disconnect, 01 toggle, 10 clear, 11 set on match.
// RULE3 - Fast PWM: 10 clears on match, sets at bottom; 11 the inverse.
// RULE4 - Fast PWM with compare at top and upper mode bit: ignore match, keep bottom action.
// RULE5 - Phase PWM: 10 clears on up match, sets on down match; 11 inverse.
// RULE6 - Phase PWM with compare at top and upper mode bit: ignore match, act at top.
// RULE7 - Clock select 000 stops, 001 undivided, 010 to 101 divide by 8/64/256/1024.
// RULE8 - Clock select 110 counts falling, 111 rising edges of external count input.
// RULE9 - External edges count regardless of the pin direction.
// RULE10 - Counter readable and writable; a write blocks the match on the next tick.
// RULE11 - Compare value continuously compared with the counter for waveform and flag.
// RULE12 - Compare interrupt when its enable, global enable and compare flag are set.
// RULE13 - Overflow interrupt when its enable, global enable and overflow flag are set.
// RULE14 - Compare flag set on match, cleared by vector taken or writing one.
// RULE15 - Overflow flag set on overflow, cleared by vector taken or writing one.
// RULE16 - Phase PWM sets overflow flag when direction reverses at zero.
// RULE17 - Waveform mode selects normal, phase PWM, clear-on-match or fast PWM behaviour.
// RULE18 - Force strobe applies non-PWM action only, no flag, reads zero.
// RULE19 - Bus access answers in one cycle; software counter write beats the increment.
module timer8_core (
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  timer8_pkg::wb_req_s      wb_i,
  output timer8_pkg::wb_rsp_s      wb_o,
  input  wire logic                external_count_input_i,
  input  wire logic                global_irq_en_i,
  input  wire logic                cmp_vector_taken_i,
  input  wire logic                ovf_vector_taken_i,
  output logic                     compare_output_pin_o,
  output logic                     compare_output_pin_oe_n_o,
  output logic                     irq_o
);
  import timer8_pkg::*;

  tstate_s    s_q;
  tstate_s    s_d;
  logic [3:0] pre_tick;
  logic       req;
  logic       wr;
  logic [5:0] idx;
  logic [7:0] wdat;
  mode_e      mode;
  logic [1:0] com;
  logic       tick;
  logic       ext_rise;
  logic       ext_fall;
  logic       match;
  logic       at_top_ignore;
  logic       up;
  logic       set_ovf;
  logic       set_cmp;
  logic [1:0] clr;
  logic       oc_n;
  mode_e      new_mode;
  logic [1:0] new_com;

  prescale_div u_pre (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .tick_o (pre_tick)
  );

  // ****************************************
  // Decoding of bus and control fields.
  // ****************************************
  assign req      = wb_i.cyc & wb_i.stb & ~s_q.ack;
  assign wr       = req & wb_i.we & wb_i.sel[0];
  assign idx      = wb_i.adr[7:2];
  assign wdat     = wb_i.dat[7:0];
  assign mode     = mode_e'({s_q.ctrl[CTRL_WGM_HI], s_q.ctrl[CTRL_WGM_LO]});
  assign com      = s_q.ctrl[CTRL_COM_HI:CTRL_COM_LO];
  assign new_mode = mode_e'({wdat[CTRL_WGM_HI], wdat[CTRL_WGM_LO]});
  assign new_com  = wdat[CTRL_COM_HI:CTRL_COM_LO];
  assign ext_rise = s_q.sync[1] & ~s_q.sync[2];
  assign ext_fall = ~s_q.sync[1] & s_q.sync[2];

  // ****************************************
  // Timer clock selection.
  // ****************************************
  always_comb begin
    // RULE7 RULE8 clock source select.
    case (cs_e'(s_q.ctrl[2:0]))
      CS_STOP:     tick = 1'b0;
      CS_DIV1:     tick = 1'b1;
      CS_DIV8:     tick = pre_tick[0];
      CS_DIV64:    tick = pre_tick[1];
      CS_DIV256:   tick = pre_tick[2];
      CS_DIV1024:  tick = pre_tick[3];
      CS_EXT_FALL: tick = ext_fall;
      CS_EXT_RISE: tick = ext_rise;
      default:     tick = 1'b0;
    endcase
  end

  // RULE11 continuous compare.
  assign match         = tick & (s_q.count == s_q.ocr) & ~s_q.block;
  assign at_top_ignore = (s_q.ocr == CNT_MAX) & com[1];
  assign up            = ~s_q.down | (s_q.count == CNT_BOTTOM);

  // ****************************************
  // Next state.
  // ****************************************
  always_comb begin
    s_d     = s_q;
    set_ovf = 1'b0;
    set_cmp = 1'b0;
    oc_n    = s_q.oc;
    clr     = 2'b00;
    s_d.ack = req;
    // RULE9 synchroniser ignores pin direction.
    s_d.sync = {s_q.sync[1:0], external_count_input_i};
    if (tick) begin
      s_d.block = 1'b0;
      // RULE17 mode dependent sequence.
      case (mode)
        MODE_NORMAL, MODE_CTC: begin
          if (mode == MODE_CTC && s_q.count == s_q.ocr) begin
            s_d.count = CNT_BOTTOM;
          end else begin
            s_d.count = s_q.count + 8'h01;
          end
          if (s_q.count == CNT_MAX) begin
            set_ovf = 1'b1;
          end
          if (match) begin
            set_cmp = 1'b1;
            // RULE2 non-PWM actions.
            case (com)
              2'b01:   oc_n = ~s_q.oc;
              2'b10:   oc_n = 1'b0;
              2'b11:   oc_n = 1'b1;
              default: oc_n = s_q.oc;
            endcase
          end
        end
        MODE_FAST: begin
          s_d.count = s_q.count + 8'h01;
          if (match) begin
            set_cmp = 1'b1;
            // RULE4 match at top ignored.
            if (!at_top_ignore) begin
              // RULE3 match action.
              if (com == 2'b10) begin
                oc_n = 1'b0;
              end else if (com == 2'b11) begin
                oc_n = 1'b1;
              end
            end
          end
          if (s_q.count == CNT_MAX) begin
            set_ovf     = 1'b1;
            s_d.ocr     = s_q.ocr_buf;
            // RULE3 RULE4 bottom action.
            if (com == 2'b10) begin
              oc_n = 1'b1;
            end else if (com == 2'b11) begin
              oc_n = 1'b0;
            end
          end
        end
        MODE_PHASE: begin
          if (!s_q.down) begin
            if (s_q.count == CNT_MAX) begin
              s_d.down  = 1'b1;
              s_d.count = s_q.count - 8'h01;
              s_d.ocr   = s_q.ocr_buf;
            end else begin
              s_d.count = s_q.count + 8'h01;
            end
          end else if (s_q.count == CNT_BOTTOM) begin
            // RULE16 overflow at direction change.
            s_d.down  = 1'b0;
            s_d.count = s_q.count + 8'h01;
            set_ovf   = 1'b1;
          end else begin
            s_d.count = s_q.count - 8'h01;
          end
          if (match) begin
            set_cmp = 1'b1;
            // RULE5 direction dependent action.
            if (!at_top_ignore && com[1]) begin
              oc_n = com[0] ? up : ~up;
            end
          end
          // RULE6 top action when match ignored.
          if (at_top_ignore && s_q.count == CNT_MAX) begin
            oc_n = ~com[0];
          end
        end
        default: begin
          s_d.count = s_q.count;
        end
      endcase
    end
    s_d.oc = oc_n;

    // RULE19 software writes take priority.
    if (wr) begin
      case (idx)
        IDX_COUNT: begin
          // RULE10 block next match.
          s_d.count = wdat;
          s_d.block = 1'b1;
        end
        IDX_COMPARE: begin
          s_d.ocr_buf = wdat;
          if (mode == MODE_NORMAL || mode == MODE_CTC) begin
            s_d.ocr = wdat;
          end
        end
        IDX_CTRL: begin
          // RULE18 strobe not stored.
          s_d.ctrl = {1'b0, wdat[6:0]};
          if (wdat[CTRL_FOC] && (new_mode == MODE_NORMAL || new_mode == MODE_CTC)) begin
            case (new_com)
              2'b01:   s_d.oc = ~oc_n;
              2'b10:   s_d.oc = 1'b0;
              2'b11:   s_d.oc = 1'b1;
              default: s_d.oc = oc_n;
            endcase
          end
        end
        IDX_FLAG: clr = wdat[1:0];
        IDX_MASK: s_d.mask = {6'h00, wdat[1:0]};
        IDX_PIN:  s_d.pinc = wdat[1:0];
        default:  s_d.pinc = s_q.pinc;
      endcase
    end

    // RULE14 RULE15 sticky flags, set wins.
    clr[FLAG_CMP] = clr[FLAG_CMP] | cmp_vector_taken_i;
    clr[FLAG_OVF] = clr[FLAG_OVF] | ovf_vector_taken_i;
    s_d.flags     = (s_q.flags & ~clr) | {set_cmp, set_ovf};

    // RULE12 RULE13 gated interrupt.
    s_d.irq = global_irq_en_i & (|(s_d.flags & s_d.mask[1:0]));

    // RULE1 pin override and driver.
    s_d.pin      = (s_d.ctrl[CTRL_COM_HI:CTRL_COM_LO] != 2'b00) ? s_d.oc : s_d.pinc[PIN_DATA];
    s_d.pin_oe_n = ~s_d.pinc[PIN_DIR];

    s_d.rdat = 32'h0000_0000;
    if (req && !wb_i.we) begin
      case (idx)
        IDX_FLAG:    s_d.rdat = {30'h0, s_q.flags};
        IDX_CTRL:    s_d.rdat = {24'h0, s_q.ctrl};
        IDX_COUNT:   s_d.rdat = {24'h0, s_q.count};
        IDX_COMPARE: s_d.rdat = {24'h0, s_q.ocr_buf};
        IDX_MASK:    s_d.rdat = {24'h0, s_q.mask};
        IDX_PIN:     s_d.rdat = {30'h0, s_q.pinc};
        default:     s_d.rdat = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= TSTATE_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign wb_o.ack                  = s_q.ack;
  assign wb_o.dat                  = s_q.rdat;
  assign compare_output_pin_o      = s_q.pin;
  assign compare_output_pin_oe_n_o = s_q.pin_oe_n;
  assign irq_o                     = s_q.irq;

  // ****************************************
  // Assertions.
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_ack_one;
    req |=> s_q.ack ##1 !s_q.ack;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack not single cycle"); // RULE19

  property p_cnt_write;
    (wr && idx == IDX_COUNT) |=> s_q.count == $past(wdat) && s_q.block;
  endproperty
  a_cnt_write: assert property (p_cnt_write) else $error("counter write lost"); // RULE10

  property p_block;
    (s_q.block && tick && !s_q.flags[FLAG_CMP] && !(wr && idx == IDX_COUNT)) |=> !s_q.flags[FLAG_CMP];
  endproperty
  a_block: assert property (p_block) else $error("blocked match set flag"); // RULE10

  property p_stop;
    (s_q.ctrl[2:0] == 3'b000 && !wr) |=> $stable(s_q.count);
  endproperty
  a_stop: assert property (p_stop) else $error("stopped counter moved"); // RULE7

  property p_div1;
    (s_q.ctrl[2:0] == 3'b001 && mode == MODE_NORMAL && !wr) |=> s_q.count == $past(s_q.count) + 8'h01;
  endproperty
  a_div1: assert property (p_div1) else $error("undivided count missed"); // RULE7

  property p_ext_rise;
    (s_q.ctrl[2:0] == 3'b111 && mode == MODE_NORMAL && !ext_rise && !wr) |=> $stable(s_q.count);
  endproperty
  a_ext_rise: assert property (p_ext_rise) else $error("count without rising edge"); // RULE8

  property p_ovf_normal;
    (tick && mode == MODE_NORMAL && s_q.count == CNT_MAX) |=> s_q.flags[FLAG_OVF];
  endproperty
  a_ovf_normal: assert property (p_ovf_normal) else $error("overflow flag not set"); // RULE15

  property p_ovf_phase;
    (tick && mode == MODE_PHASE && s_q.down && s_q.count == CNT_BOTTOM) |=> s_q.flags[FLAG_OVF] && !s_q.down;
  endproperty
  a_ovf_phase: assert property (p_ovf_phase) else $error("phase overflow wrong"); // RULE16

  property p_irq;
    1'b1 |=> s_q.irq == ($past(global_irq_en_i) && (|(s_q.flags & s_q.mask[1:0])));
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt level wrong"); // RULE12

  property p_set_match;
    (match && mode == MODE_NORMAL && com == 2'b11 && !wr) |=> s_q.oc && s_q.flags[FLAG_CMP];
  endproperty
  a_set_match: assert property (p_set_match) else $error("set on match failed"); // RULE2

  property p_pin_dir;
    s_q.pin_oe_n == !s_q.pinc[PIN_DIR];
  endproperty
  a_pin_dir: assert property (p_pin_dir) else $error("pin driver mismatch"); // RULE1

  property p_foc_zero;
    s_q.ctrl[CTRL_FOC] == 1'b0;
  endproperty
  a_foc_zero: assert property (p_foc_zero) else $error("force strobe stored"); // RULE18

  c_irq:   cover property (!s_q.irq ##1 s_q.irq);
  c_turn:  cover property (mode == MODE_PHASE && !s_q.down ##1 s_q.down);
  c_ext:   cover property (s_q.ctrl[2:0] == 3'b110 && ext_fall);
  c_fast:  cover property (mode == MODE_FAST && match);

endmodule

// *** test/pin_world_model.sv ***
`timescale 1ns/100ps
// ****************************************
// Pin side: external count source and pad.
// ****************************************
module pin_world_model (
  input  wire logic clk_i,
  input  wire logic pin_i,
  input  wire logic pin_oe_n_i,
  output logic      count_o,
  output logic      level_o
);
  initial count_o = 1'b0;
  // The pad has a weak pull-down, so an undriven pin reads low.
  assign level_o = pin_oe_n_i ? 1'b0 : pin_i;
  // Each pulse is six cycles high and seven low between pulses, well above the input synchroniser.
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge clk_i);
      count_o <= 1'b1;
      repeat (6) @(posedge clk_i);
      count_o <= 1'b0;
      repeat (6) @(posedge clk_i);
    end
  endtask
endmodule

// *** test/timer8_core_tb_top.sv ***
`timescale 1ns/100ps
module timer8_core_tb_top;
  import timer8_pkg::*;
  logic       clk_i = 1'b0;
  logic       rst_i = 1'b1;
  wb_req_s    wb_i  = '0;
  wb_rsp_s    wb_o;
  logic       glob  = 1'b0;
  logic       cvt   = 1'b0;
  logic       ovt   = 1'b0;
  logic       ext;
  logic       pin;
  logic       pin_oe_n;
  logic       irq;
  logic       lvl;
  logic [7:0] rd;
  int         err_total = 0;
  int         tests_run = 0;
  logic [5:0] idxs [7]  = '{IDX_FLAG, IDX_CTRL, IDX_COUNT, IDX_COMPARE, IDX_MASK, IDX_PIN, 6'h01};
  logic [7:0] pre_cs [5] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05};
  int         pre_n [5]  = '{198, 798, 6398, 2558, 10238};
  int         pre_e [5]  = '{200, 100, 100, 10, 10};
  logic [7:0] fc_cfg [6] = '{8'h90, 8'h90, 8'hB0, 8'hA0, 8'hB0, 8'hA0};
  logic [7:0] fc_exp [6] = '{8'h01, 8'h00, 8'h01, 8'h00, 8'h01, 8'h00};
  logic [7:0] pw_cfg [5] = '{8'h69, 8'h79, 8'h61, 8'h61, 8'h71};
  logic [7:0] pw_ocr [5] = '{8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00};
  logic [7:0] pw_exp [5] = '{8'h01, 8'h00, 8'h01, 8'h00, 8'h01};

  always #2.5 clk_i = ~clk_i;

  timer8_core i_timer8_core (
    .clk_i                     (clk_i),
    .rst_i                     (rst_i),
    .wb_i                      (wb_i),
    .wb_o                      (wb_o),
    .external_count_input_i    (ext),
    .global_irq_en_i           (glob),
    .cmp_vector_taken_i        (cvt),
    .ovf_vector_taken_i        (ovt),
    .compare_output_pin_o      (pin),
    .compare_output_pin_oe_n_o (pin_oe_n),
    .irq_o                     (irq)
  );

  pin_world_model i_pin_world (
    .clk_i      (clk_i),
    .pin_i      (pin),
    .pin_oe_n_i (pin_oe_n),
    .count_o    (ext),
    .level_o    (lvl)
  );

  // ****************************************
  // Shared tasks.
  // ****************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic we, input logic [5:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_i <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: {idx, 2'b00}, sel: 4'h1, dat: {24'h000000, d}};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_o.ack !== 1'b1 && n < 50);
    if (wb_o.ack !== 1'b1) begin
      check(8'h00, 8'h01);
    end
    rd = wb_o.dat[7:0];
    wb_i <= '0;
  endtask

  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d);
  endtask

  task automatic rdchk(input logic [5:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    check(rd, exp);
  endtask

  task automatic end_sim;
    $display("Comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    #200000;
    err_total++;
    end_sim();
  end

  // ****************************************
  // Test sequence.
  // ****************************************
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (idxs[i]) rdchk(idxs[i], 8'h00);
    check({7'h00, pin_oe_n}, 8'h01);
    wr(IDX_COMPARE, 8'h5A);
    rdchk(IDX_COMPARE, 8'h5A);
    wr(IDX_COUNT, 8'hA5);
    rdchk(IDX_COUNT, 8'hA5);
    wr(IDX_MASK, 8'hFF);
    rdchk(IDX_MASK, 8'h03);
    wr(6'h01, 8'h77);
    rdchk(6'h01, 8'h00);
    wr(IDX_MASK, 8'h00);
    repeat (50) @(posedge clk_i);
    rdchk(IDX_COUNT, 8'hA5);
    $display("TEST registers end");
    wr(IDX_COMPARE, 8'h80);
    wr(IDX_COUNT, 8'hF0);
    wr(IDX_CTRL, 8'h01);
    repeat (30) @(posedge clk_i);
    wr(IDX_CTRL, 8'h00);
    rdchk(IDX_FLAG, 8'h01);
    wr(IDX_MASK, 8'h01);
    repeat (3) @(posedge clk_i);
    check({7'h00, irq}, 8'h00);
    glob <= 1'b1;
    repeat (3) @(posedge clk_i);
    check({7'h00, irq}, 8'h01);
    ovt <= 1'b1;
    @(posedge clk_i);
    ovt <= 1'b0;
    repeat (3) @(posedge clk_i);
    check({7'h00, irq}, 8'h00);
    rdchk(IDX_FLAG, 8'h00);
    wr(IDX_COUNT, 8'h70);
    wr(IDX_CTRL, 8'h01);
    repeat (30) @(posedge clk_i);
    wr(IDX_CTRL, 8'h00);
    rdchk(IDX_FLAG, 8'h02);
    wr(IDX_MASK, 8'h02);
    repeat (3) @(posedge clk_i);
    check({7'h00, irq}, 8'h01);
    cvt <= 1'b1;
    @(posedge clk_i);
    cvt <= 1'b0;
    repeat (3) @(posedge clk_i);
    check({7'h00, irq}, 8'h00);
    rdchk(IDX_FLAG, 8'h00);
    wr(IDX_COUNT, 8'h80);
    wr(IDX_CTRL, 8'h01);
    repeat (5) @(posedge clk_i);
    wr(IDX_CTRL, 8'h00);
    rdchk(IDX_FLAG, 8'h00);
    $display("TEST flags end");
    wr(IDX_PIN, 8'h01);
    foreach (fc_cfg[i]) begin
      wr(IDX_CTRL, fc_cfg[i]);
      repeat (2) @(posedge clk_i);
      check({7'h00, lvl}, fc_exp[i]);
    end
    check({7'h00, pin_oe_n}, 8'h00);
    rdchk(IDX_CTRL, 8'h20);
    rdchk(IDX_FLAG, 8'h00);
    wr(IDX_PIN, 8'h03);
    wr(IDX_CTRL, 8'h00);
    repeat (2) @(posedge clk_i);
    check({7'h00, lvl}, 8'h01);
    wr(IDX_PIN, 8'h00);
    repeat (2) @(posedge clk_i);
    check({7'h00, pin_oe_n}, 8'h01);
    $display("TEST force end");
    foreach (pre_cs[i]) begin
      wr(IDX_COUNT, 8'h00);
      wr(IDX_CTRL, pre_cs[i]);
      repeat (pre_n[i]) @(posedge clk_i);
      wr(IDX_CTRL, 8'h00);
      bus(1'b0, IDX_COUNT, 8'h00);
      check({7'h00, (rd inside {[pre_e[i] - 1 : pre_e[i] + 1]})}, 8'h01);
    end
    for (int c = 6; c < 8; c++) begin
      wr(IDX_COUNT, 8'h00);
      wr(IDX_CTRL, 8'(c));
      i_pin_world.pulses(5);
      repeat (6) @(posedge clk_i);
      wr(IDX_CTRL, 8'h00);
      rdchk(IDX_COUNT, 8'h05);
    end
    $display("TEST clocks end");
    wr(IDX_PIN, 8'h01);
    foreach (pw_cfg[i]) begin
      wr(IDX_CTRL, 8'h00);
      wr(IDX_COMPARE, pw_ocr[i]);
      wr(IDX_COUNT, 8'h00);
      wr(IDX_CTRL, pw_cfg[i]);
      repeat (600) @(posedge clk_i);
      repeat (4) begin
        check({7'h00, lvl}, pw_exp[i]);
        repeat (131) @(posedge clk_i);
      end
    end
    wr(IDX_CTRL, 8'h00);
    bus(1'b0, IDX_FLAG, 8'h00);
    check({7'h00, rd[FLAG_OVF]}, 8'h01);
    wr(IDX_FLAG, 8'h03);
    rdchk(IDX_FLAG, 8'h00);
    $display("TEST pwm end");
    wr(IDX_COMPARE, 8'h10);
    wr(IDX_COUNT, 8'h00);
    wr(IDX_CTRL, 8'h09);
    repeat (40) @(posedge clk_i);
    wr(IDX_CTRL, 8'h00);
    bus(1'b0, IDX_COUNT, 8'h00);
    check({7'h00, (rd inside {[8'h08 : 8'h0A]})}, 8'h01);
    rdchk(IDX_FLAG, 8'h02);
    $display("TEST clear on match end");
    end_sim();
  end
endmodule
